// >>> acc_pkg.sv
// Constants, register map and types of the converter control block
package acc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTL0_OFS = 8'h00;
  localparam logic [7:0] CTL1_OFS = 8'h04;
  localparam logic [7:0] CTL2_OFS = 8'h08;
  localparam logic [7:0] RES_OFS  = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;

  // converter_control_0 fields
  localparam int MSC_BIT   = 0;
  localparam int ENC_BIT   = 1;
  localparam int ON_BIT    = 4;
  localparam int SHARED_REFERENCE_ON_BIT_BIT = 5;

  // converter_control_1 fields
  localparam int SEQ_LSB  = 0;
  localparam int SHP_BIT  = 2;
  localparam int TSEL_BIT = 3;
  localparam int DIV_LSB  = 4;
  localparam int PDIV_LSB = 8;
  localparam int SSEL_LSB = 10;
  localparam int SLEN_LSB = 12;
  localparam int BUSY_BIT = 16;

  // converter_control_2 fields
  localparam int SHARED_REFERENCE_OUTPUT_BIT_BIT = 0;

  // Interrupt status and mask bits
  localparam int DONE_BIT = 0;
  localparam int HALT_BIT = 1;
  localparam int TOV_BIT  = 2;

  // Writable bits and reset values
  localparam logic [31:0] CTL0_WMASK = 32'h0000_0032;
  localparam logic [31:0] CTL1_WMASK = 32'h0000_ffff;
  localparam logic [31:0] CTL2_WMASK = 32'h0000_0001;
  localparam logic [31:0] CTL_RST    = 32'h0000_0000;
  localparam logic [2:0]  IRQ_RST    = 3'h0;

  // Sequence modes
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_SEQ    = 2'h1;
  localparam logic [1:0] SEQ_REP    = 2'h2;
  localparam logic [1:0] SEQ_REPSEQ = 2'h3;

  // Conversion timing in conversion-clock ticks
  localparam logic [4:0] SAMPLE_TICKS = 5'h04;
  localparam logic [4:0] CONV_TICKS   = 5'h0d;

  typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONV, ACC_HALT} acc_state_type;

endpackage

// >>> acc_sync2.sv
// Two-flop synchroniser for pin inputs
module acc_sync2 import acc_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// >>> acc_clkdiv.sv
// Conversion clock tick generator with divider and predivider
module acc_clkdiv import acc_pkg::*; #(
  parameter int CW = 9
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       en,
  input  wire logic [2:0] div,
  input  wire logic [1:0] pdiv,
  // Tick out
  output logic            tick
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] load;

  // Total division is (div+1) times 1, 4 or 64
  always_comb begin
    case (pdiv)
      2'h0:    load = CW'({6'h00, div});
      2'h1:    load = CW'({4'h0, div, 2'h3});
      default: load = CW'({div, 6'h3f});
    endcase
  end

  // Counter held at zero without a request, saving power
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (!en) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == '0);
      cnt_q <= (cnt_q == '0) ? load : cnt_q - CW'(1);
    end
  end

endmodule

// >>> acc_top.sv
// Converter control block with AHB-Lite register slave
module acc_top import acc_pkg::*; (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Converter side
  input  wire logic        timer_trig,
  input  wire logic [11:0] sar_result,
  output logic             clk_req,
  output logic             sample_hold,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] ctl0_q;
  logic [31:0] ctl1_q;
  logic [31:0] ctl2_q;
  logic [11:0] res_q;
  logic [2:0]  stat_q;
  logic [2:0]  mask_q;
  logic [31:0] rdata;
  logic        aphase;
  logic        busy;

  assign aphase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= aphase && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  // Unmapped offsets read zero and ignore writes
  always_comb begin
    case (haddr[7:0])
      CTL0_OFS: rdata = ctl0_q;
      CTL1_OFS: rdata = ctl1_q | (32'(busy) << BUSY_BIT);
      CTL2_OFS: rdata = ctl2_q;
      RES_OFS:  rdata = {20'h00000, res_q};
      STAT_OFS: rdata = {29'h0, stat_q};
      MASK_OFS: rdata = {29'h0, mask_q};
      default:  rdata = 32'h0000_0000;
    endcase
  end

  // Zero wait states; always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (aphase && !hwrite) ? rdata : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  logic wr_ctl0;
  logic enc;
  logic pwr;
  logic enc_new;
  logic pwr_new;

  assign wr_ctl0 = wr_q && (wa_q == CTL0_OFS);
  assign enc     = ctl0_q[ENC_BIT];
  assign pwr     = ctl0_q[ON_BIT];
  assign enc_new = wr_ctl0 ? hwdata[ENC_BIT] : enc;
  assign pwr_new = wr_ctl0 ? hwdata[ON_BIT] : pwr;

  // Start bit is not stored, it acts only as a strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_q <= CTL_RST;
      ctl1_q <= CTL_RST;
      ctl2_q <= CTL_RST;
      mask_q <= IRQ_RST;
    end else if (wr_q) begin
      if (wa_q == CTL0_OFS) ctl0_q <= hwdata & CTL0_WMASK;
      if (wa_q == CTL1_OFS) ctl1_q <= hwdata & CTL1_WMASK;
      if (wa_q == CTL2_OFS) ctl2_q <= hwdata & CTL2_WMASK;
      if (wa_q == MASK_OFS) mask_q <= hwdata[2:0];
    end
  end

  logic [1:0] mode;
  logic [3:0] seq_len;

  assign mode    = ctl1_q[SEQ_LSB +: 2];
  assign seq_len = ctl1_q[SLEN_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////
  // Clock request and trigger sources

  // Request follows enable at once, not the first trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) clk_req <= 1'b0;
    else          clk_req <= enc_new && pwr_new;
  end

  logic tick;

  acc_clkdiv u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .en      (clk_req),
    .div     (ctl1_q[DIV_LSB +: 3]),
    .pdiv    (ctl1_q[PDIV_LSB +: 2]),
    .tick    (tick)
  );

  logic tt_s;
  logic tt_d_q;

  acc_sync2 #(.W(1)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (timer_trig),
    .q       (tt_s)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tt_d_q <= 1'b0;
    else          tt_d_q <= tt_s;
  end

  logic tsel;
  logic trig_tmr;
  logic trig_man;
  logic trig_wr;
  logic trig;
  logic armed_q;
  logic can_start;

  assign tsel     = ctl1_q[TSEL_BIT];
  // Timer edge only counts in pulse-sample mode
  assign trig_tmr = tsel && ctl1_q[SHP_BIT] && tt_s && !tt_d_q;
  assign trig_man = wr_ctl0 && hwdata[MSC_BIT];
  // Known quirk kept: with tsel set in single mode, any control_0 write arms a sample here
  assign trig_wr  = wr_ctl0 && tsel && (mode == SEQ_SINGLE);
  assign trig     = (trig_tmr || trig_man || trig_wr) && enc_new && pwr_new;

  // Single mode needs enable toggled low again before a new manual or timer start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                         armed_q <= 1'b0;
    else if (!enc)                        armed_q <= 1'b1;
    else if (trig && !busy && mode == SEQ_SINGLE && !trig_wr) armed_q <= 1'b0;
  end

  assign can_start = armed_q || (mode != SEQ_SINGLE) || trig_wr;

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  acc_state_type st_q;
  logic [4:0]    tk_q;
  logic [3:0]    sc_q;
  logic          overlap;
  logic          ev_done;
  logic          ev_halt;
  logic          ev_tov;

  assign busy    = (st_q == ACC_SAMPLE) || (st_q == ACC_CONV);
  assign overlap = trig && busy;
  assign ev_halt = overlap && (mode != SEQ_SINGLE);
  // No overflow report once halted; software must not count on it
  assign ev_tov  = overlap && trig_tmr && (mode == SEQ_SINGLE);
  assign ev_done = (st_q == ACC_CONV) && tick && (tk_q == CONV_TICKS - 5'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ACC_IDLE;
      tk_q <= 5'h00;
      sc_q <= 4'h0;
    end else begin
      case (st_q)
        ACC_IDLE: begin
          if (trig && can_start) begin
            st_q <= ACC_SAMPLE;
            tk_q <= 5'h00;
            sc_q <= 4'h0;
          end
        end
        ACC_SAMPLE, ACC_CONV: begin
          if (!pwr_new) begin
            st_q <= ACC_IDLE;
          end else if (ev_halt) begin
            st_q <= ACC_HALT;
          end else if (tick) begin
            tk_q <= tk_q + 5'h01;
            if (st_q == ACC_SAMPLE && tk_q == SAMPLE_TICKS - 5'h01) begin
              st_q <= ACC_CONV;
              tk_q <= 5'h00;
            end else if (ev_done) begin
              tk_q <= 5'h00;
              if (mode[0] && sc_q != seq_len) begin
                st_q <= ACC_SAMPLE;
                sc_q <= sc_q + 4'h1;
              end else begin
                st_q <= ACC_IDLE;
              end
            end
          end
        end
        ACC_HALT: begin
          // Only a full power-down clears the halt
          if (!enc && !pwr) st_q <= ACC_IDLE;
        end
        default: st_q <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)     res_q <= 12'h000;
    else if (ev_done) res_q <= sar_result;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sample_hold <= 1'b0;
    else          sample_hold <= (st_q == ACC_SAMPLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [2:0] ev;
  logic [2:0] clr;

  assign ev  = {ev_tov, ev_halt, ev_done};
  assign clr = (wr_q && wa_q == STAT_OFS) ? hwdata[2:0] : 3'h0;

  // New event wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stat_q <= IRQ_RST;
    else          stat_q <= (stat_q & ~clr) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else          irq <= |(stat_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_clk_req;
    @(posedge hclk) disable iff (!hresetn)
    (wr_ctl0 && hwdata[ENC_BIT] && hwdata[ON_BIT]) |=> clk_req ##1 u_div.en;
  endproperty
  a_clk_req: assert property (p_clk_req) else $error("no clock request on enable");

  property p_wr_start;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == ACC_IDLE && wr_ctl0 && tsel && mode == SEQ_SINGLE
      && hwdata[ENC_BIT] && hwdata[ON_BIT]) |=> (st_q == ACC_SAMPLE) ##1 sample_hold;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write did not start sampling");

  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
    (busy && trig && mode != SEQ_SINGLE && pwr_new) |=> (st_q == ACC_HALT) ##1 stat_q[HALT_BIT];
  endproperty
  a_halt: assert property (p_halt) else $error("overlap did not halt");

  property p_halt_hold;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == ACC_HALT && (enc || pwr)) |=> (st_q == ACC_HALT) && !busy;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left early");

  property p_manual;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == ACC_IDLE && wr_ctl0 && hwdata[MSC_BIT] && hwdata[ENC_BIT]
      && hwdata[ON_BIT] && can_start) |=> busy ##1 sample_hold;
  endproperty
  a_manual: assert property (p_manual) else $error("manual start ignored");

  property p_tov;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == ACC_HALT) |=> !$rose(stat_q[TOV_BIT]);
  endproperty
  a_tov: assert property (p_tov) else $error("overflow raised while halted");

  property p_recover;
    @(posedge hclk) disable iff (!hresetn)
    (st_q == ACC_HALT && !enc && !pwr) |=> (st_q == ACC_IDLE) ##1 !busy;
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery from halt");

  property p_busy_end;
    @(posedge hclk) disable iff (!hresetn)
    $fell(busy) |-> ($past(ev_done) && ($past(sc_q) == seq_len || !mode[0]))
      || !$past(pwr_new) || st_q == ACC_HALT;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy dropped early");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (|(stat_q & mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// >>> acc_timer_model.sv
// Timer trigger source model driving the converter control block
module acc_timer_model #(
  parameter int          MIN_GAP = 600,
  parameter logic [11:0] LEVEL   = 12'h5a3
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench commands
  input  wire logic        fire,
  input  wire logic        fast,
  // Converter side
  output logic             timer_trig,
  output logic      [11:0] sar_result
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned gap_q;
  int unsigned hi_q;

  // Analogue input held steady, so every capture sees the same level
  assign sar_result = LEVEL;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse three cycles wide so the two-flop synchroniser cannot miss it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q      <= MIN_GAP;
      hi_q       <= 0;
      timer_trig <= 1'b0;
    end else if (fire && hi_q == 0 && (fast || gap_q >= MIN_GAP)) begin
      gap_q      <= 0;
      hi_q       <= 3;
      timer_trig <= 1'b1;
    end else begin
      if (gap_q < MIN_GAP) begin
        gap_q <= gap_q + 1;
      end
      if (hi_q != 0) begin
        hi_q <= hi_q - 1;
      end
      timer_trig <= (hi_q > 1);
    end
  end
endmodule

// >>> acc_top_tb_top.sv
// Self-checking bench of the converter control block
module acc_top_tb_top import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [11:0] LEVEL = 12'h5a3;
  // Divide by 8 keeps the conversion clock at 2.5 MHz
  localparam logic [31:0] CLK8  = 32'h0000_0070;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        timer_trig;
  logic [11:0] sar_result;
  logic        clk_req;
  logic        sample_hold;
  logic        irq;
  logic        fire;
  logic        fast;
  logic [31:0] rd;
  int          n_mismatch;
  int          checked;

  acc_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_trig(timer_trig),
    .sar_result(sar_result), .clk_req(clk_req), .sample_hold(sample_hold), .irq(irq)
  );

  acc_timer_model #(.MIN_GAP(600), .LEVEL(LEVEL)) timer (
    .hclk(hclk), .hresetn(hresetn), .fire(fire), .fast(fast),
    .timer_trig(timer_trig), .sar_result(sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, CTL1_OFS, 32'h0);
      n++;
    end while (rd[BUSY_BIT] !== 1'b0 && n < 400);
    chk("busy clears", 32'h0, 32'(rd[BUSY_BIT]));
  endtask

  task automatic pulse(input logic f);
    @(posedge hclk);
    fire <= 1'b1;
    fast <= f;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("ctl0 reset", CTL0_OFS, CTL_RST);
    rchk("ctl1 reset", CTL1_OFS, CTL_RST);
    rchk("ctl2 reset", CTL2_OFS, CTL_RST);
    rchk("status reset", STAT_OFS, 32'h0);
    rchk("mask reset", MASK_OFS, 32'h0);
    chk("hresp", 32'h0, 32'(hresp));
    bus(1'b1, CTL0_OFS, 32'hffff_ffcc);
    rchk("ctl0 unused bits", CTL0_OFS, 32'h0);
    bus(1'b1, 8'h18, 32'hffff_ffff);
    rchk("unmapped", 8'h18, 32'h0);
    bus(1'b1, CTL2_OFS, 32'h1);
    rchk("ctl2 shared_reference_output_bit", CTL2_OFS, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_enable;
    bus(1'b1, CTL1_OFS, CLK8 | 32'h4);
    bus(1'b1, CTL0_OFS, 32'h30);
    repeat (2) @(posedge hclk);
    chk("clk_req disabled", 32'h0, 32'(clk_req));
    bus(1'b1, CTL0_OFS, 32'h32);
    repeat (2) @(posedge hclk);
    chk("clk_req enabled", 32'h1, 32'(clk_req));
    chk("no sampling yet", 32'h0, 32'(sample_hold));
    rchk("idle before trigger", CTL1_OFS, CLK8 | 32'h4);
    $display("test enable done");
  endtask

  task automatic t_manual;
    int n;
    bus(1'b1, MASK_OFS, 32'h7);
    bus(1'b1, CTL0_OFS, 32'h33);
    rchk("busy after start", CTL1_OFS, CLK8 | 32'h0001_0004);
    n = 0;
    while (sample_hold !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk("sample_hold", 32'h1, 32'(sample_hold));
    wait_idle;
    rchk("result", RES_OFS, {20'h0, LEVEL});
    rchk("done flag", STAT_OFS, 32'h1);
    chk("irq raised", 32'h1, 32'(irq));
    bus(1'b1, MASK_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, MASK_OFS, 32'h7);
    bus(1'b1, STAT_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, 32'(irq));
    rchk("status cleared", STAT_OFS, 32'h0);
    $display("test manual done");
  endtask

  task automatic t_write;
    bus(1'b1, CTL0_OFS, 32'h10);
    bus(1'b1, CTL1_OFS, CLK8 | 32'hc);
    bus(1'b1, CTL0_OFS, 32'h10);
    rchk("no start disabled", CTL1_OFS, CLK8 | 32'hc);
    bus(1'b1, CTL0_OFS, 32'h32);
    rchk("write starts", CTL1_OFS, CLK8 | 32'h1_000c);
    pulse(1'b1);
    rchk("overlap mode 0", CTL1_OFS, CLK8 | 32'h1_000c);
    wait_idle;
    rchk("overflow flag", STAT_OFS, 32'h5);
    bus(1'b1, CTL0_OFS, 32'h12);
    rchk("any write starts", CTL1_OFS, CLK8 | 32'h1_000c);
    wait_idle;
    bus(1'b1, STAT_OFS, 32'h7);
    $display("test write trigger done");
  endtask

  // Predivide by 4 with divide by 4 gives 1.25 MHz, twice the CLK8 run time
  task automatic t_prediv;
    bus(1'b1, CTL0_OFS, 32'h10);
    bus(1'b1, CTL1_OFS, 32'h0000_0134);
    bus(1'b1, CTL0_OFS, 32'h13);
    repeat ((SAMPLE_TICKS + CONV_TICKS) * 12) @(posedge hclk);
    rchk("prediv busy", CTL1_OFS, 32'h0001_0134);
    wait_idle;
    rchk("prediv result", RES_OFS, {20'h0, LEVEL});
    bus(1'b1, STAT_OFS, 32'h7);
    $display("test prediv done");
  endtask

  task automatic t_halt;
    logic [31:0] c1;
    for (int m = 1; m < 4; m++) begin
      c1 = CLK8 | 32'h300c | 32'(m);
      repeat (700) @(posedge hclk);
      bus(1'b1, CTL0_OFS, 32'h10);
      bus(1'b1, CTL1_OFS, c1);
      bus(1'b1, CTL0_OFS, 32'h12);
      pulse(1'b0);
      rchk("timer starts", CTL1_OFS, c1 | 32'h1_0000);
      pulse(1'b1);
      rchk("halt busy", CTL1_OFS, c1);
      rchk("halt flag", STAT_OFS, 32'h2);
      pulse(1'b1);
      rchk("halt holds", CTL1_OFS, c1);
      bus(1'b1, CTL0_OFS, 32'h0);
      bus(1'b1, CTL0_OFS, 32'h12);
      pulse(1'b1);
      rchk("resumed", CTL1_OFS, c1 | 32'h1_0000);
      bus(1'b1, CTL0_OFS, 32'h0);
      rchk("power abort", CTL1_OFS, c1);
      bus(1'b1, STAT_OFS, 32'h7);
    end
    $display("test halt done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    fire       = 1'b0;
    fast       = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_enable;
    t_manual;
    t_write;
    t_prediv;
    t_halt;
    wrap_up;
  end

  // Whole run is near 3200 cycles; six times that means a hang
  initial begin
    #1_000_000;
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up;
  end
endmodule
